/* design/lvd_pkg.sv */
package lvd_pkg;

  // register map of this block
  localparam logic [3:0] LVD_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] LVD_ADDR_MFI    = 4'h1;
  localparam logic [3:0] LVD_ADDR_STATUS = 4'h2;
  localparam logic [3:0] LVD_ADDR_MASK   = 4'h3;

  // control register fields
  localparam int LVD_CTRL_SEL_LSB = 0;
  localparam int LVD_CTRL_VBG_BIT = 3;
  localparam int LVD_CTRL_EN_BIT  = 4;
  localparam int LVD_CTRL_UV_BIT  = 5;
  localparam logic [7:0] LVD_CTRL_RESET = 8'h00;

  // multi-function interrupt register fields
  localparam int LVD_MFI_IE_BIT   = 0;
  localparam int LVD_MFI_FLAG_BIT = 4;
  localparam logic [7:0] LVD_MFI_RESET = 8'h00;

  // status / mask bits
  localparam int LVD_ST_FLAG_BIT = 0;
  localparam int LVD_ST_UV_BIT   = 1;
  localparam logic [1:0] LVD_ST_RESET = 2'h0;

  localparam logic [2:0] LVD_SEL_EXT_PIN = 3'h0;

  // timing at 25 MHz
  localparam int LVD_CLK_NS        = 40;
  localparam int LVD_IRQ_DELAY_NS  = 120;
  localparam int LVD_IRQ_DELAY_CYC = (LVD_IRQ_DELAY_NS + LVD_CLK_NS - 1) / LVD_CLK_NS;
  localparam logic [7:0] LVD_IRQ_DELAY_CNT = 8'(LVD_IRQ_DELAY_CYC);

  typedef struct packed {
    logic       uv_meta;
    logic       uv_sync;
    logic       uv_prev;
    logic [7:0] dly_cnt;
    logic       dly_run;
    logic       det_en;
    logic       vbg_en;
    logic [2:0] sel;
    logic       irq_ie;
    logic       irq_flag;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] rdata;
    logic       irq;
    logic       wake;
    logic       req;
    logic       det_on;
    logic       bg_on;
    logic       sense_ext;
  } lvd_state_s;

endpackage : lvd_pkg

/* design/lvd_top.sv */
// Contract
// RULE_01 - detector_enable at bit 4 switches the detector on when 1, off when 0
// RULE_02 - threshold_select codes 001 to 111 pick supply trip levels 2.2V to 4.0V
// RULE_03 - code 000 compares the external sense pin with 1.04V, else the supply
// RULE_04 - undervoltage_flag at bit 5 reads 1 while sensed voltage is below threshold
// RULE_05 - sleep mode forces the detector off regardless of detector_enable
// RULE_06 - software waits the settle delay before trusting undervoltage_flag
// RULE_07 - irq flag sets only after irq_delay following undervoltage_flag rising
// RULE_08 - pending low voltage request wakes from idle; set flag first to avoid (code: a preset flag with enable set also wakes)
// RULE_09 - bandgap on when detector on, reset function on, or bit 3 written 1
// RULE_10 - control bits 7 and 6 read zero; implemented bits clear at reset
// RULE_11 - software tolerates flag chatter near threshold; no filtering applied
// RULE_12 - low voltage request goes out through a multi-function interrupt group
// RULE_13 - low_voltage_irq_flag sits at bit 4 of the interrupt register
// RULE_14 - low_voltage_irq_enable sits at bit 0 and gates the request
// RULE_15 - irq flag stays set until written 0; software may set it by writing 1
`timescale 1ns/1ps
module lvd_top (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic       sleep_mode,
  input  wire logic       idle_mode,
  input  wire logic       lvr_enable,
  input  wire logic       comp_below,
  output logic            detector_on,
  output logic            bandgap_on,
  output logic      [2:0] threshold_select,
  output logic            sense_external,
  output logic            mf_irq_req,
  output logic            idle_wake,
  output logic            irq
);

  lvd_pkg::lvd_state_s st_r;
  lvd_pkg::lvd_state_s st_nxt;

  function automatic logic [7:0] ctrl_word(input lvd_pkg::lvd_state_s s);
    logic [7:0] w;
    w = 8'h00;  // bits 7:6 stay zero  RULE_10
    w[lvd_pkg::LVD_CTRL_SEL_LSB +: 3] = s.sel;
    w[lvd_pkg::LVD_CTRL_VBG_BIT]      = s.vbg_en;
    w[lvd_pkg::LVD_CTRL_EN_BIT]       = s.det_en;
    w[lvd_pkg::LVD_CTRL_UV_BIT]       = s.uv_sync;  // RULE_04
    return w;
  endfunction : ctrl_word

  always_comb begin
    logic det_act;
    logic uv_now;
    logic rise;
    logic flag_set;
    det_act = 1'b0;
    uv_now = 1'b0;
    rise = 1'b0;
    flag_set = 1'b0;
    st_nxt = st_r;

    det_act = st_r.det_en & ~sleep_mode;  // RULE_01 RULE_05
    // comparator is analogue and asynchronous; two stages before use
    st_nxt.uv_meta = comp_below & det_act;
    st_nxt.uv_sync = st_r.uv_meta & det_act;  // RULE_04
    uv_now = st_r.uv_sync;
    // each rising chatter edge restarts the delay, each falling edge cancels it; no filtering  RULE_11
    st_nxt.uv_prev = uv_now;
    rise = uv_now & ~st_r.uv_prev;

    if (rise) begin
      st_nxt.dly_run = 1'b1;  // RULE_07
      st_nxt.dly_cnt = lvd_pkg::LVD_IRQ_DELAY_CNT;
    end else if (!uv_now) begin
      st_nxt.dly_run = 1'b0;
      st_nxt.dly_cnt = 8'h00;
    end else if (st_r.dly_run) begin
      if (st_r.dly_cnt == 8'h01) begin
        st_nxt.dly_run = 1'b0;
        flag_set = 1'b1;  // RULE_07
      end
      st_nxt.dly_cnt = st_r.dly_cnt - 8'h01;
    end

    if (wr_stb) begin
      unique case (addr)
        lvd_pkg::LVD_ADDR_CTRL: begin
          st_nxt.sel    = wdata[lvd_pkg::LVD_CTRL_SEL_LSB +: 3];  // RULE_02
          st_nxt.vbg_en = wdata[lvd_pkg::LVD_CTRL_VBG_BIT];
          st_nxt.det_en = wdata[lvd_pkg::LVD_CTRL_EN_BIT];  // RULE_01
        end
        lvd_pkg::LVD_ADDR_MFI: begin
          st_nxt.irq_ie   = wdata[lvd_pkg::LVD_MFI_IE_BIT];  // RULE_14
          st_nxt.irq_flag = wdata[lvd_pkg::LVD_MFI_FLAG_BIT];  // RULE_15
        end
        lvd_pkg::LVD_ADDR_STATUS: st_nxt.status = st_r.status & ~wdata[1:0];
        lvd_pkg::LVD_ADDR_MASK:   st_nxt.mask = wdata[1:0];
        default: ;
      endcase
    end
    // hardware set wins over a software clear in the same cycle
    if (flag_set) st_nxt.irq_flag = 1'b1;  // RULE_15
    if (flag_set) st_nxt.status[lvd_pkg::LVD_ST_FLAG_BIT] = 1'b1;
    if (rise) st_nxt.status[lvd_pkg::LVD_ST_UV_BIT] = 1'b1;

    st_nxt.rdata = 8'h00;
    if (rd_stb) begin
      unique case (addr)
        lvd_pkg::LVD_ADDR_CTRL: st_nxt.rdata = ctrl_word(st_r);
        lvd_pkg::LVD_ADDR_MFI: begin
          st_nxt.rdata[lvd_pkg::LVD_MFI_IE_BIT]   = st_r.irq_ie;  // RULE_14
          st_nxt.rdata[lvd_pkg::LVD_MFI_FLAG_BIT] = st_r.irq_flag;  // RULE_13
        end
        lvd_pkg::LVD_ADDR_STATUS: st_nxt.rdata = {6'h00, st_r.status};
        lvd_pkg::LVD_ADDR_MASK:   st_nxt.rdata = {6'h00, st_r.mask};
        default:                  st_nxt.rdata = 8'h00;
      endcase
    end

    st_nxt.det_on    = det_act;
    st_nxt.bg_on     = det_act | lvr_enable | st_r.vbg_en;  // RULE_09
    st_nxt.sense_ext = (st_r.sel == lvd_pkg::LVD_SEL_EXT_PIN);  // RULE_03
    st_nxt.irq       = |(st_nxt.status & st_nxt.mask);
    // registered so the request pin comes straight from a flop  RULE_12
    st_nxt.req       = st_nxt.irq_flag & st_nxt.irq_ie;  // RULE_14
    // a pending request wakes idle; a preset flag with irq_ie set wakes it as well  RULE_08
    st_nxt.wake      = idle_mode & st_nxt.irq_flag & st_nxt.irq_ie;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;  // RULE_10
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata            = st_r.rdata;
  assign detector_on      = st_r.det_on;
  assign bandgap_on       = st_r.bg_on;
  assign threshold_select = st_r.sel;  // RULE_02
  assign sense_external   = st_r.sense_ext;  // RULE_03
  assign mf_irq_req       = st_r.req;  // RULE_12
  assign idle_wake        = st_r.wake;
  assign irq              = st_r.irq;

endmodule : lvd_top

/* dv/lvd_comp_model.sv */
`timescale 1ns/1ps
module lvd_comp_model (
  input  wire logic       detector_on,
  input  wire logic [2:0] threshold_select,
  input  wire logic       sense_external,
  input  var  int         vdd_mv,
  input  var  int         ext_mv,
  output logic            comp_below
);
  // trip levels in mV; no hysteresis, so slow inputs chatter here as well
  localparam int TRIP_MV [8] = '{1040, 2200, 2400, 2700, 3000, 3300, 3600, 4000};
  assign comp_below = detector_on &&
    ((sense_external ? ext_mv : vdd_mv) < TRIP_MV[threshold_select]);
endmodule : lvd_comp_model

/* dv/lvd_top_monitor.sv */
`timescale 1ns/1ps
module lvd_top_monitor (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       sleep_mode,
  input wire logic       idle_mode,
  input wire logic       lvr_enable,
  input wire logic       comp_below,
  input wire logic       detector_on,
  input wire logic       bandgap_on,
  input wire logic [2:0] threshold_select,
  input wire logic       sense_external,
  input wire logic       mf_irq_req,
  input wire logic       idle_wake
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_det_enable: assert property (wr_stb && addr == 4'h0 && !sleep_mode ##1 !sleep_mode
    ##1 !sleep_mode |-> detector_on == $past(wdata[4], 2)) else $error("enable bit ignored");
  a_sleep_off: assert property (sleep_mode |=> !detector_on) else $error("on in sleep");
  a_bg_on: assert property (detector_on || lvr_enable |-> ##[0:1] bandgap_on)
    else $error("bandgap off");
  a_ext_sense: assert property ($changed(threshold_select) |=>
    sense_external == (threshold_select == 3'h0)) else $error("wrong sense source");
  a_irq_delay: assert property ($rose(mf_irq_req) && !$past(wr_stb) |->
    $past(comp_below, 4)) else $error("request too early");
  a_req_gate: assert property (wr_stb && addr == 4'h1 && !wdata[0] |=> !mf_irq_req)
    else $error("request not gated");
  a_flag_hold: assert property (mf_irq_req && !wr_stb |=> mf_irq_req)
    else $error("flag lost");
  a_idle_wake: assert property ((idle_mode && mf_irq_req) [*2] |-> idle_wake)
    else $error("no wake");
  c_wake: cover property (idle_wake);
  c_req: cover property ($rose(mf_irq_req));
  c_sleep: cover property (sleep_mode && detector_on);
endmodule : lvd_top_monitor

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic       mclk = 0, rst = 1, wr_stb = 0, rd_stb = 0, sleep_mode = 0, idle_mode = 0;
  logic       lvr_enable = 0, comp_below, detector_on, bandgap_on, sense_external;
  logic       mf_irq_req, idle_wake, irq;
  logic [2:0] threshold_select;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  int         vdd_mv = 5000, ext_mv = 1000, fails = 0, num_checks = 0, n;
  localparam logic [3:0] A_CTL = lvd_pkg::LVD_ADDR_CTRL, A_MFI = lvd_pkg::LVD_ADDR_MFI;
  always #20 mclk = ~mclk;
  lvd_top dut_u (.mclk, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .sleep_mode,
    .idle_mode, .lvr_enable, .comp_below, .detector_on, .bandgap_on, .threshold_select,
    .sense_external, .mf_irq_req, .idle_wake, .irq);
  lvd_comp_model cmp_u (.detector_on, .threshold_select, .sense_external, .vdd_mv,
    .ext_mv, .comp_below);
  task automatic chk(input string what, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk) wr_stb <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk) rd_stb <= 1'b0;
    @(negedge mclk) chk("rdata", rdata, exp);
    @(posedge mclk);
  endtask : rd
  task automatic end_of_test;
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int a = 0; a < 4; a++) rd(4'(a), 8'h00);
    rd(4'hF, 8'h00);
    wr(A_CTL, 8'hFF);
    rd(A_CTL, 8'h1F);
    chk("outs", {detector_on, bandgap_on, sense_external, threshold_select}, 8'h37);
    sleep_mode <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("sleep", detector_on, 8'h00);
    sleep_mode <= 1'b0;
    vdd_mv <= 3100;
    for (int s = 0; s < 8; s++) begin
      wr(A_CTL, 8'h10 | 8'(s));
      repeat (3) @(posedge mclk);
      rd(A_CTL, {2'h0, s == 0 || s > 4, 5'h10 | 5'(s)});
      chk("sense", sense_external, 8'(s == 0));
    end
    vdd_mv <= 5000;
    wr(A_MFI, 8'h01);
    wr(lvd_pkg::LVD_ADDR_STATUS, 8'h03);
    rd(A_MFI, 8'h01);
    vdd_mv <= 2000;
    n = 0;
    while (mf_irq_req !== 1'b1 && n < 20) @(posedge mclk) n++;
    chk("delay", 8'(n > 2 + lvd_pkg::LVD_IRQ_DELAY_CYC && n < 20), 8'h01);
    if (n == 20) end_of_test();
    idle_mode <= 1'b1;
    wr(lvd_pkg::LVD_ADDR_MASK, 8'h01);
    @(posedge mclk);
    chk("wake", {idle_wake, irq}, 8'h03);
    vdd_mv <= 5000;
    rd(lvd_pkg::LVD_ADDR_STATUS, 8'h03);
    rd(A_MFI, 8'h11);
    wr(A_MFI, 8'h10);
    rd(A_MFI, 8'h10);
    chk("req", mf_irq_req, 8'h00);
    wr(A_MFI, 8'h00);
    wr(lvd_pkg::LVD_ADDR_STATUS, 8'h03);
    @(posedge mclk);
    chk("clear", {idle_wake, irq}, 8'h00);
    wr(A_CTL, 8'h00);
    lvr_enable <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("bg_lvr", bandgap_on, 8'h01);
    lvr_enable <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("bg_off", bandgap_on, 8'h00);
    end_of_test();
  end
endmodule : testbench
bind lvd_top lvd_top_monitor mon_u (.*);
